/* hdl/gpm_regs.vh */
// register offsets, field positions and reset values of the gpio port
`ifndef GPM_REGS_VH
`define GPM_REGS_VH

// bus address width and the masked data window
`define GPM_ADDR_W 12
`define GPM_MASK_LSB 2
`define GPM_MASK_MSB 9

// word offsets of the control and status registers
`define GPM_DIR 12'h400
`define GPM_SENSE 12'h404
`define GPM_BOTH 12'h408
`define GPM_POL 12'h40C
`define GPM_MASK 12'h410
`define GPM_RAW 12'h414
`define GPM_MSTAT 12'h418
`define GPM_CLEAR 12'h41C
`define GPM_AFSEL 12'h420
`define GPM_DR2 12'h500
`define GPM_DR4 12'h504
`define GPM_DR8 12'h508
`define GPM_ODR 12'h50C
`define GPM_PUR 12'h510
`define GPM_PDR 12'h514
`define GPM_SLR 12'h518
`define GPM_DEN 12'h51C
`define GPM_LOCK 12'h520
`define GPM_COMMIT 12'h524

// identification words sit in the last twelve words of the page
`define GPM_ID_TOP 6'h3F
`define GPM_ID_SKIP 4'h4

// reset values
`define GPM_ZERO8 8'h00
`define GPM_ALL8 8'hFF
`define GPM_DR2_RST 8'hFF
`define GPM_NO_PROTECT 8'h00
`define GPM_PROTECT_B 8'h80
`define GPM_PROTECT_C 8'h0F

// unlock key of the commit lock, arbitrary value
`define GPM_UNLOCK_KEY 32'h5EC0_0DE5

// pin that also feeds the converter trigger
`define GPM_TRIG_BIT 4

`endif

/* hdl/gpm_sync.v */
// two-flop synchroniser for the pad inputs
`timescale 1ns/1ps
module gpm_sync #(
	parameter W = 8
) (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// raw and synchronised levels
	input wire [W-1:0] async_in,
	output reg [W-1:0] sync_out
);

reg [W-1:0] meta_reg;

// first stage feeds only the second stage
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		meta_reg <= {W{1'b0}};
		sync_out <= {W{1'b0}};
	end else begin
		meta_reg <= async_in;
		sync_out <= meta_reg;
	end
end

endmodule // gpm_sync

/* hdl/gpm_irq_sense.v */
// per-pin trigger detection: edge or level, single or both edges
`timescale 1ns/1ps
module gpm_irq_sense #(
	parameter W = 8
) (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// synchronised pin levels
	input wire [W-1:0] level_in,
	// trigger controls
	input wire [W-1:0] sense_level,
	input wire [W-1:0] both_edges,
	input wire [W-1:0] polarity_high,
	// condition met this cycle
	output reg [W-1:0] cond
);

reg [W-1:0] prev_reg;
reg primed_reg;

// no edge is seen until one real sample has been taken
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		prev_reg <= {W{1'b0}};
		primed_reg <= 1'b0;
	end else begin
		prev_reg <= level_in;
		primed_reg <= 1'b1;
	end
end

// level follows polarity; both-edges overrides polarity for edges
always @* begin
	cond = (sense_level & ~(level_in ^ polarity_high)) |
		(~sense_level & {W{primed_reg}} & (
		(both_edges & (level_in ^ prev_reg)) |
		(~both_edges & polarity_high & level_in & ~prev_reg) |
		(~both_edges & ~polarity_high & ~level_in & prev_reg)));
end

endmodule // gpm_irq_sense

/* hdl/gpm_port.v */
// one gpio port: apb registers, masked data, interrupt, pad control
//
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "gpm_regs.vh"
module gpm_port #(
	parameter [7:0] PROTECT_MASK = `GPM_NO_PROTECT,
	parameter TRIG_ENABLE = 0
) (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [`GPM_ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// pads
	input wire [7:0] pin_in,
	output wire [7:0] pin_out,
	output wire [7:0] pin_oe,
	// pad electrical controls
	output wire [7:0] pad_drive_2ma,
	output wire [7:0] pad_drive_4ma,
	output wire [7:0] pad_drive_8ma,
	output wire [7:0] pad_open_drain,
	output wire [7:0] pad_pull_up,
	output wire [7:0] pad_pull_down,
	output wire [7:0] pad_slew_limit,
	output wire [7:0] pad_digital_en,
	// alternate function peripherals
	input wire [7:0] periph_out,
	input wire [7:0] periph_oe,
	output wire [7:0] periph_in,
	// interrupt and converter trigger
	output wire port_irq,
	output wire conv_trigger
);

// block state
reg [7:0] data_reg;
reg [7:0] dir_reg;
reg [7:0] sense_reg;
reg [7:0] both_reg;
reg [7:0] pol_reg;
reg [7:0] mask_reg;
reg [7:0] raw_reg;
reg [7:0] afsel_reg;
reg [7:0] dr2_reg;
reg [7:0] dr4_reg;
reg [7:0] dr8_reg;
reg [7:0] odr_reg;
reg [7:0] pur_reg;
reg [7:0] pdr_reg;
reg [7:0] slr_reg;
reg [7:0] den_reg;
reg [7:0] commit_reg;
reg locked_reg;
// registered outputs
reg [31:0] prdata_reg;
reg pready_reg;
reg pslverr_reg;
reg [7:0] pin_out_reg;
reg [7:0] pin_oe_reg;
reg [7:0] periph_in_reg;
reg irq_reg;
reg conv_reg;
// next values
reg [7:0] data_next;
reg [7:0] raw_next;
reg [7:0] out_sel;
reg [7:0] oe_sel;
reg [31:0] rd_data;
reg rd_err;

wire [7:0] pin_sync;
wire [7:0] cond;
wire [7:0] addr_mask;
wire data_hit;
wire id_hit;
wire setup;
wire wr_en;
wire [7:0] clr;
wire [7:0] af_allow;
wire [7:0] commit_allow;

// true when the word address matches a register offset
function hit;
	input [`GPM_ADDR_W-1:0] a;
	input [`GPM_ADDR_W-1:0] off;
	begin
		hit = (a[`GPM_ADDR_W-1:2] == off[`GPM_ADDR_W-1:2]);
	end
endfunction

// take new bits where mask is set, keep old elsewhere
function [7:0] merge;
	input [7:0] old;
	input [7:0] nw;
	input [7:0] m;
	begin
		merge = (old & ~m) | (nw & m);
	end
endfunction

// identification table, values arbitrary
function [7:0] id_word;
	input [3:0] i;
	begin
		case (i)
		4'h0: id_word = 8'h00;
		4'h1: id_word = 8'h00;
		4'h2: id_word = 8'h00;
		4'h3: id_word = 8'h00;
		4'h4: id_word = 8'h61;
		4'h5: id_word = 8'h02;
		4'h6: id_word = 8'h1A;
		4'h7: id_word = 8'h03;
		4'h8: id_word = 8'h0D;
		4'h9: id_word = 8'hF0;
		4'hA: id_word = 8'h05;
		4'hB: id_word = 8'hB1;
		default: id_word = 8'h00;
		endcase
	end
endfunction

// pad levels cross into pclk before anything reads them
gpm_sync #(
	.W(8)
) u_sync (
	.pclk(pclk),
	.presetn(presetn),
	.async_in(pin_in),
	.sync_out(pin_sync)
);

gpm_irq_sense #(
	.W(8)
) u_sense (
	.pclk(pclk),
	.presetn(presetn),
	.level_in(pin_sync),
	.sense_level(sense_reg),
	.both_edges(both_reg),
	.polarity_high(pol_reg),
	.cond(cond)
);

// bus decode; writes land on the access edge with pready high
assign setup = psel & ~penable;
assign wr_en = psel & penable & pwrite & pready_reg;
assign data_hit = (paddr[11:10] == 2'b00);
assign addr_mask = paddr[`GPM_MASK_MSB:`GPM_MASK_LSB];
assign id_hit = (paddr[11:6] == `GPM_ID_TOP) &&
	(paddr[5:2] >= `GPM_ID_SKIP);
assign clr = (wr_en && hit(paddr, `GPM_CLEAR)) ? pwdata[7:0] :
	`GPM_ZERO8;

// protected alt bits need an open lock and a set commit bit
assign af_allow = ~PROTECT_MASK | (commit_reg & {8{~locked_reg}});
// commit bits of unprotected pins are read-only ones
assign commit_allow = PROTECT_MASK & {8{~locked_reg}};

// data register: writes masked by address, inputs follow the pad
always @* begin
	data_next = data_reg;
	if (wr_en && data_hit)
		data_next = merge(data_reg, pwdata[7:0], addr_mask);
	data_next = merge(data_next, pin_sync, ~dir_reg);
end

// raw status: edges latch until cleared, levels follow the pin;
// a new edge in the clear cycle wins over the clear
always @* begin
	raw_next = (sense_reg & cond) |
		(~sense_reg & ((raw_reg & ~clr) | cond));
end

// software mode or peripheral mode per pin
always @* begin
	out_sel = merge(data_reg, periph_out, afsel_reg);
	oe_sel = merge(dir_reg, periph_oe, afsel_reg);
end

// register read mux; unmapped words answer with an error
always @* begin
	rd_data = 32'h0000_0000;
	rd_err = 1'b0;
	if (data_hit) begin
		rd_data[7:0] = data_reg & addr_mask;
	end else if (id_hit) begin
		rd_data[7:0] = id_word(paddr[5:2] - `GPM_ID_SKIP);
	end else if (hit(paddr, `GPM_DIR)) begin
		rd_data[7:0] = dir_reg;
	end else if (hit(paddr, `GPM_SENSE)) begin
		rd_data[7:0] = sense_reg;
	end else if (hit(paddr, `GPM_BOTH)) begin
		rd_data[7:0] = both_reg;
	end else if (hit(paddr, `GPM_POL)) begin
		rd_data[7:0] = pol_reg;
	end else if (hit(paddr, `GPM_MASK)) begin
		rd_data[7:0] = mask_reg;
	end else if (hit(paddr, `GPM_RAW)) begin
		rd_data[7:0] = raw_reg;
	end else if (hit(paddr, `GPM_MSTAT)) begin
		rd_data[7:0] = raw_reg & mask_reg;
	end else if (hit(paddr, `GPM_CLEAR)) begin
		rd_data[7:0] = `GPM_ZERO8;
	end else if (hit(paddr, `GPM_AFSEL)) begin
		rd_data[7:0] = afsel_reg;
	end else if (hit(paddr, `GPM_DR2)) begin
		rd_data[7:0] = dr2_reg;
	end else if (hit(paddr, `GPM_DR4)) begin
		rd_data[7:0] = dr4_reg;
	end else if (hit(paddr, `GPM_DR8)) begin
		rd_data[7:0] = dr8_reg;
	end else if (hit(paddr, `GPM_ODR)) begin
		rd_data[7:0] = odr_reg;
	end else if (hit(paddr, `GPM_PUR)) begin
		rd_data[7:0] = pur_reg;
	end else if (hit(paddr, `GPM_PDR)) begin
		rd_data[7:0] = pdr_reg;
	end else if (hit(paddr, `GPM_SLR)) begin
		rd_data[7:0] = slr_reg;
	end else if (hit(paddr, `GPM_DEN)) begin
		rd_data[7:0] = den_reg;
	end else if (hit(paddr, `GPM_LOCK)) begin
		rd_data[0] = locked_reg;
	end else if (hit(paddr, `GPM_COMMIT)) begin
		rd_data[7:0] = commit_reg;
	end else begin
		rd_err = 1'b1;
	end
end

// apb answer: one cycle after setup, so no wait states
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		prdata_reg <= 32'h0000_0000;
		pready_reg <= 1'b0;
		pslverr_reg <= 1'b0;
	end else begin
		pready_reg <= setup;
		pslverr_reg <= setup & rd_err;
		if (setup && !pwrite)
			prdata_reg <= rd_data;
	end
end

// data and direction
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		data_reg <= `GPM_ZERO8;
		dir_reg <= `GPM_ZERO8;
	end else begin
		data_reg <= data_next;
		if (wr_en && hit(paddr, `GPM_DIR))
			dir_reg <= pwdata[7:0];
	end
end

// interrupt controls and status
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		sense_reg <= `GPM_ZERO8;
		both_reg <= `GPM_ZERO8;
		pol_reg <= `GPM_ZERO8;
		mask_reg <= `GPM_ZERO8;
		raw_reg <= `GPM_ZERO8;
	end else begin
		raw_reg <= raw_next;
		if (wr_en && hit(paddr, `GPM_SENSE))
			sense_reg <= pwdata[7:0];
		if (wr_en && hit(paddr, `GPM_BOTH))
			both_reg <= pwdata[7:0];
		if (wr_en && hit(paddr, `GPM_POL))
			pol_reg <= pwdata[7:0];
		if (wr_en && hit(paddr, `GPM_MASK))
			mask_reg <= pwdata[7:0];
	end
end

// mode, lock and commit; debug pins come up in their debug role
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		afsel_reg <= PROTECT_MASK;
		commit_reg <= ~PROTECT_MASK;
		locked_reg <= 1'b1;
	end else begin
		if (wr_en && hit(paddr, `GPM_AFSEL))
			afsel_reg <= merge(afsel_reg, pwdata[7:0], af_allow);
		if (wr_en && hit(paddr, `GPM_COMMIT))
			commit_reg <= merge(commit_reg, pwdata[7:0], commit_allow);
		// any value but the key closes the lock again
		if (wr_en && hit(paddr, `GPM_LOCK))
			locked_reg <= (pwdata != `GPM_UNLOCK_KEY);
	end
end

// drive strength: one select at a time, setting one clears the others
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		dr2_reg <= `GPM_DR2_RST;
		dr4_reg <= `GPM_ZERO8;
		dr8_reg <= `GPM_ZERO8;
	end else if (wr_en && hit(paddr, `GPM_DR2)) begin
		dr2_reg <= pwdata[7:0];
		dr4_reg <= dr4_reg & ~pwdata[7:0];
		dr8_reg <= dr8_reg & ~pwdata[7:0];
	end else if (wr_en && hit(paddr, `GPM_DR4)) begin
		dr2_reg <= dr2_reg & ~pwdata[7:0];
		dr4_reg <= pwdata[7:0];
		dr8_reg <= dr8_reg & ~pwdata[7:0];
	end else if (wr_en && hit(paddr, `GPM_DR8)) begin
		dr2_reg <= dr2_reg & ~pwdata[7:0];
		dr4_reg <= dr4_reg & ~pwdata[7:0];
		dr8_reg <= pwdata[7:0];
	end
end

// remaining pad controls
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		odr_reg <= `GPM_ZERO8;
		pur_reg <= PROTECT_MASK;
		pdr_reg <= `GPM_ZERO8;
		slr_reg <= `GPM_ZERO8;
		den_reg <= PROTECT_MASK;
	end else begin
		if (wr_en && hit(paddr, `GPM_ODR))
			odr_reg <= pwdata[7:0];
		if (wr_en && hit(paddr, `GPM_PUR))
			pur_reg <= pwdata[7:0];
		if (wr_en && hit(paddr, `GPM_PDR))
			pdr_reg <= pwdata[7:0];
		if (wr_en && hit(paddr, `GPM_SLR))
			slr_reg <= pwdata[7:0];
		if (wr_en && hit(paddr, `GPM_DEN))
			den_reg <= pwdata[7:0];
	end
end

// pad drive: open drain only pulls low; disabled pads stay undriven
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		pin_out_reg <= `GPM_ZERO8;
		pin_oe_reg <= `GPM_ZERO8;
		periph_in_reg <= `GPM_ZERO8;
	end else begin
		pin_out_reg <= out_sel & ~odr_reg;
		pin_oe_reg <= oe_sel & den_reg & ~(odr_reg & out_sel);
		periph_in_reg <= pin_sync & den_reg;
	end
end

// one port interrupt; trigger pulses on a fresh unmasked event
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		irq_reg <= 1'b0;
		conv_reg <= 1'b0;
	end else begin
		irq_reg <= |(raw_reg & mask_reg);
		conv_reg <= (TRIG_ENABLE != 0) && mask_reg[`GPM_TRIG_BIT] &&
			cond[`GPM_TRIG_BIT] && !raw_reg[`GPM_TRIG_BIT];
	end
end

// outputs straight from flops
assign prdata = prdata_reg;
assign pready = pready_reg;
assign pslverr = pslverr_reg;
assign pin_out = pin_out_reg;
assign pin_oe = pin_oe_reg;
assign periph_in = periph_in_reg;
assign pad_drive_2ma = dr2_reg;
assign pad_drive_4ma = dr4_reg;
assign pad_drive_8ma = dr8_reg;
assign pad_open_drain = odr_reg;
assign pad_pull_up = pur_reg;
assign pad_pull_down = pdr_reg;
assign pad_slew_limit = slr_reg;
assign pad_digital_en = den_reg;
assign port_irq = irq_reg;
assign conv_trigger = conv_reg;

endmodule // gpm_port

/* testbench/gpm_port_asserts.sv */
// concurrent checks on the bus and pad ports of one gpio port
`timescale 1ns/1ps
module gpm_port_asserts #(
	parameter [7:0] PROTECT_MASK = 8'h00,
	parameter TRIG_ENABLE = 0
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// pads
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	input wire logic [7:0] pad_drive_2ma,
	input wire logic [7:0] pad_drive_4ma,
	input wire logic [7:0] pad_drive_8ma,
	input wire logic [7:0] pad_open_drain,
	input wire logic [7:0] pad_pull_up,
	input wire logic [7:0] pad_digital_en,
	// events
	input wire logic port_irq,
	input wire logic conv_trigger
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// bus steps
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_answer;
		pready ##1 !pready;
	endsequence
	a_ready_pulse: assert property (s_setup |=> s_answer)
		else $error("pready not a one-cycle answer to setup");
	a_ready_access: assert property (pready |-> psel && penable)
		else $error("pready outside an access cycle");
	a_err_read: assert property (pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read returned data");
	a_reset_pads: assert property ($rose(presetn) |-> pin_oe == 8'h00 &&
		pad_pull_up == PROTECT_MASK && pad_digital_en == PROTECT_MASK)
		else $error("pad defaults wrong after reset");
	a_drive_excl: assert property (((pad_drive_2ma & pad_drive_4ma) |
		(pad_drive_8ma & (pad_drive_2ma | pad_drive_4ma))) == 8'h00)
		else $error("two drive strengths selected");
	a_open_drain: assert property (
		(pin_out & pad_open_drain & $past(pad_open_drain)) == 8'h00)
		else $error("open-drain pin driven high");
	a_trig_pulse: assert property (conv_trigger |=> !conv_trigger)
		else $error("converter trigger longer than one cycle");
	a_trig_irq: assert property (conv_trigger |=> port_irq)
		else $error("converter trigger without port interrupt");
endmodule // gpm_port_asserts

/* testbench/gpm_pad_model.sv */
// pad model: resolves each pad from the port and the outside world
`timescale 1ns/1ps
module gpm_pad_model (
	// clock
	input wire logic pclk,
	// port side
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	input wire logic [7:0] pad_pull_up,
	input wire logic [7:0] pad_pull_down,
	// outside sources
	input wire logic [7:0] ext_val,
	input wire logic [7:0] ext_drive,
	// resolved levels
	output logic [7:0] pin_in
);
	logic [7:0] float_reg = 8'h00;
	integer i;
	// a floating pad toggles so no stale level can pass for a real one
	always @(posedge pclk) float_reg <= ~pin_in;
	// port drive wins, then outside source, then pulls
	always @* begin
		for (i = 0; i < 8; i = i + 1) begin
			if (pin_oe[i]) pin_in[i] = pin_out[i];
			else if (ext_drive[i]) pin_in[i] = ext_val[i];
			else if (pad_pull_up[i]) pin_in[i] = 1'h1;
			else if (pad_pull_down[i]) pin_in[i] = 1'h0;
			else pin_in[i] = float_reg[i];
		end
	end
endmodule // gpm_pad_model

/* testbench/test_gpio_port_masked_data_irq.sv */
// self-checking bench for one gpio port configured as port b
`timescale 1ns/1ps
`include "gpm_regs.vh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin err_count++; \
	$display("ERROR %s exp %h got %h", n, e, g); end end
module test_gpio_port_masked_data_irq;
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic pready, pslverr, port_irq, conv_trigger, rerr;
	logic [7:0] pin_in, pin_out, pin_oe, d2, d4, d8, od, pu, pd, slr, den, pi;
	logic [7:0] periph_out = 8'h80, periph_oe = 8'h80;
	logic [7:0] ext_val = 8'h00, ext_drive = 8'h7F;
	int err_count = 0, check_count = 0, pulses = 0;
	always #2 pclk = ~pclk;
	always @(posedge pclk) if (conv_trigger === 1'h1) pulses <= pulses + 1;
	gpm_port #(.PROTECT_MASK(8'h80), .TRIG_ENABLE(1)) dut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.pad_drive_2ma(d2), .pad_drive_4ma(d4), .pad_drive_8ma(d8),
		.pad_open_drain(od), .pad_pull_up(pu), .pad_pull_down(pd),
		.pad_slew_limit(slr), .pad_digital_en(den), .periph_out(periph_out),
		.periph_oe(periph_oe), .periph_in(pi), .port_irq(port_irq),
		.conv_trigger(conv_trigger));
	gpm_pad_model pads (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
		.pad_pull_up(pu), .pad_pull_down(pd), .ext_val(ext_val),
		.ext_drive(ext_drive), .pin_in(pin_in));
	task summarize;
		begin
			$display("checks %0d errors %0d", check_count, err_count);
			if (err_count == 0 && check_count > 0) begin
				$display("verification passed");
			end else begin
				$display("verification failed");
			end
			$finish;
		end
	endtask
	// one transfer; request held until pready is sampled high
	task apb(input [11:0] a, input w, input [31:0] d);
		int n;
		begin
			n = 0;
			psel <= 1'h1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'h1;
			@(posedge pclk);
			while (pready !== 1'h1 && n < 16) begin
				n++;
				@(posedge pclk);
			end
			if (n == 16) `CHK("pready", 1'h1, pready)
			rdat = prdata;
			rerr = pslverr;
			psel <= 1'h0;
			penable <= 1'h0;
			@(posedge pclk);
		end
	endtask
	task wr(input [11:0] a, input [31:0] d);
		apb(a, 1'h1, d);
	endtask
	task rd(input [11:0] a, input [31:0] e);
		begin
			apb(a, 1'h0, 32'h0);
			`CHK("prdata", e, rdat)
		end
	endtask
	// new outside levels, then time for sync, capture and irq
	task pins(input [7:0] v);
		begin
			ext_val <= v;
			repeat (6) @(posedge pclk);
		end
	endtask
	task t_reset;
		begin
			rd(`GPM_AFSEL, 32'h80);
			rd(`GPM_PDR, 32'h0);
			rd(`GPM_COMMIT, 32'h7F);
			`CHK("pull_up", 8'h80, pu)
			`CHK("digital_en", 8'h80, den)
			// only the debug pin is driven, by its peripheral
			`CHK("pin_oe", 8'h80, pin_oe)
		end
	endtask
	task t_data;
		begin
			wr(`GPM_DEN, 32'hFF);
			wr(`GPM_DIR, 32'h7F);
			wr(12'h098, 32'hEB);
			rd(12'h1FC, 32'h22);
			rd(12'h0C4, 32'h20);
			`CHK("pin_out", 8'hA2, pin_out)
			`CHK("pin_oe", 8'hFF, pin_oe)
			// the peripheral, not the data bit, drives the debug pin
			periph_out <= 8'h00;
			pins(8'h00);
			`CHK("pin_out", 8'h22, pin_out)
			periph_out <= 8'h80;
			wr(`GPM_DIR, 32'h00);
			pins(8'h5A);
			rd(12'h1FC, 32'h5A);
			rd(12'h03C, 32'h0A);
			`CHK("periph_in", 8'hDA, pi)
		end
	endtask
	task t_irq;
		begin
			pins(8'h00);
			wr(`GPM_MASK, 32'h00);
			wr(`GPM_SENSE, 32'h01);
			wr(`GPM_BOTH, 32'h02);
			wr(`GPM_POL, 32'h15);
			wr(`GPM_CLEAR, 32'hFF);
			wr(`GPM_MASK, 32'h13);
			pins(8'h10);
			rd(`GPM_MSTAT, 32'h10);
			`CHK("port_irq", 1'h1, port_irq)
			`CHK("pulses", 1, pulses)
			pins(8'h00);
			pins(8'h10);
			`CHK("pulses", 1, pulses)
			wr(`GPM_CLEAR, 32'h00);
			rd(`GPM_RAW, 32'h10);
			wr(`GPM_CLEAR, 32'h10);
			rd(`GPM_RAW, 32'h00);
			pins(8'h01);
			wr(`GPM_CLEAR, 32'h01);
			rd(`GPM_RAW, 32'h01);
			pins(8'h03);
			wr(`GPM_CLEAR, 32'h02);
			pins(8'h01);
			pins(8'h05);
			rd(`GPM_RAW, 32'h07);
			rd(`GPM_MSTAT, 32'h03);
			pins(8'h00);
			wr(`GPM_CLEAR, 32'hFF);
			rd(`GPM_RAW, 32'h00);
			`CHK("port_irq", 1'h0, port_irq)
		end
	endtask
	task t_commit;
		begin
			wr(`GPM_AFSEL, 32'h00);
			rd(`GPM_AFSEL, 32'h80);
			wr(`GPM_LOCK, `GPM_UNLOCK_KEY);
			rd(`GPM_LOCK, 32'h0);
			wr(`GPM_COMMIT, 32'hFF);
			rd(`GPM_COMMIT, 32'hFF);
			wr(`GPM_AFSEL, 32'h00);
			rd(`GPM_AFSEL, 32'h00);
			`CHK("pin_oe", 8'h00, pin_oe)
		end
	endtask
	task t_pad;
		begin
			wr(`GPM_DR8, 32'h01);
			wr(`GPM_ODR, 32'h02);
			wr(`GPM_DIR, 32'h02);
			wr(12'h008, 32'h02);
			wr(`GPM_SLR, 32'h04);
			wr(`GPM_PDR, 32'h40);
			pins(8'h00);
			`CHK("drive_8ma", 8'h01, d8)
			`CHK("drive_2ma", 8'hFE, d2)
			`CHK("pin_oe", 8'h00, pin_oe)
			`CHK("slew_limit", 8'h04, slr)
			`CHK("pull_down", 8'h40, pd)
			// a new strength select takes the bit from the others
			wr(`GPM_DR4, 32'h01);
			`CHK("drive_4ma", 8'h01, d4)
			`CHK("drive_8ma", 8'h00, d8)
			wr(12'h008, 32'h00);
			pins(8'h00);
			`CHK("pin_oe", 8'h02, pin_oe)
		end
	endtask
	task t_err;
		begin
			apb(12'h600, 1'h0, 32'h0);
			`CHK("pslverr", 1'h1, rerr)
			`CHK("prdata", 32'h0, rdat)
			// identification words are mapped, so no error
			apb(12'hFD0, 1'h0, 32'h0);
			`CHK("id_pslverr", 1'h0, rerr)
		end
	endtask
	// second reset in mid-run
	task t_rst2;
		begin
			presetn <= 1'h0;
			repeat (3) @(posedge pclk);
			presetn <= 1'h1;
			@(posedge pclk);
			rd(`GPM_AFSEL, 32'h80);
			rd(`GPM_DR8, 32'h00);
			`CHK("pull_up", 8'h80, pu)
		end
	endtask
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		t_reset;
		t_data;
		t_irq;
		t_commit;
		t_pad;
		t_err;
		t_rst2;
		summarize;
	end
	// cuts a hang well past the expected run length
	initial begin
		repeat (20000) @(posedge pclk);
		err_count++;
		summarize;
	end
endmodule // test_gpio_port_masked_data_irq
bind gpm_port gpm_port_asserts #(.PROTECT_MASK(PROTECT_MASK),
	.TRIG_ENABLE(TRIG_ENABLE)) u_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .pin_out(pin_out), .pin_oe(pin_oe),
	.pad_drive_2ma(pad_drive_2ma), .pad_drive_4ma(pad_drive_4ma),
	.pad_drive_8ma(pad_drive_8ma), .pad_open_drain(pad_open_drain),
	.pad_pull_up(pad_pull_up), .pad_digital_en(pad_digital_en),
	.port_irq(port_irq), .conv_trigger(conv_trigger));
